// ### hdl/list_ptr_pkg.sv
// List-pointer register bank constants and carrier types.
// Assumes one 250 MHz controller clock and a word-wide register port.
// Contract
// - Control current pointer holds descriptor address in bits 31:4; 3:0 reserved.
// - After serving a control descriptor, the current pointer advances to next.
// - Each frame resumes control processing where the previous frame stopped.
// - At control list end, test the filled flag, command status bit 1.
// - Flag set at end: reload current from control head, then clear flag.
// - Flag clear at end: pointer and flag unchanged, nothing more done.
// - Current pointer resets to zero; zero means end of control list.
// - Bulk head is 32-bit read/write, pointer in upper 28 bits, resets zero.
// - Each bulk traversal begins at the descriptor the bulk head addresses.
// - Bulk head is loaded from the communication area at initialisation.
// - Registers sit at offsets 24h and 28h from the memory base at 10h.
// - Control head holds the first control descriptor address, reload source.
package list_ptr_pkg;
   localparam logic [7:0]  CFG_MEM_BAR_OFS      = 8'h10;
   localparam logic [7:0]  CTRL_HEAD_OFS        = 8'h20;
   localparam logic [7:0]  CTRL_CUR_OFS         = 8'h24;
   localparam logic [7:0]  BULK_HEAD_OFS        = 8'h28;
   localparam int          PTR_LSB              = 4;
   localparam int          PTR_W                = 28;
   localparam int          CLF_BIT              = 1;
   localparam int          CLE_BIT              = 4;
   localparam logic [27:0] PTR_RESET            = 28'h000_0000;
   localparam logic [31:0] RESERVED_READ        = 32'h0000_0000;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic        done;
      logic        list_end;
      logic [27:0] next_ptr;
   } ed_event_t;

   function automatic logic [31:0] ptr_to_word(input logic [27:0] p);
      ptr_to_word = {p, 4'h0};
   endfunction : ptr_to_word
endpackage : list_ptr_pkg

// ### hdl/list_ptr_sync.sv
// Two-flop reset release for the list-pointer bank.
// Assumes clk_in is the controller clock.
`timescale 1ns/100ps
module list_ptr_sync (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   output logic      rst_n_out
);
   logic [1:0] sync_r;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_r <= 2'h0;
      end else begin
         sync_r <= {sync_r[0], 1'b1};
      end
   end
   assign rst_n_out = sync_r[1];
endmodule : list_ptr_sync

// ### hdl/ohci_list_pointer_regs.sv
// Control current pointer and bulk head pointer registers.
// Assumes the list engine and command registers sit on the same clock.
`timescale 1ns/100ps
module ohci_list_pointer_regs (
   input  wire logic                   clk_in,
   input  wire logic                   rst_n_in,
   input  wire list_ptr_pkg::reg_req_t req_in,
   input  wire logic [27:0]            control_list_head_pointer_in,
   input  wire logic                   control_list_filled_in,
   input  wire logic                   control_list_enable_in,
   input  wire list_ptr_pkg::ed_event_t ed_event_in,
   input  wire logic                   init_load_in,
   input  wire logic [27:0]            host_communication_area_bulk_head_in,
   input  wire logic                   bulk_start_in,
   output logic [31:0]                 rdata_out,
   output logic                        rvalid_out,
   output logic                        clear_filled_out,
   output logic [31:0]                 control_current_addr_out,
   output logic [31:0]                 bulk_start_addr_out,
   output logic                        control_list_idle_out
);
   typedef struct packed {
      logic [27:0] cur;
      logic [27:0] bulk;
      logic [31:0] rdata;
      logic        rvalid;
      logic        clr;
      logic [31:0] cur_addr;
      logic [31:0] bulk_addr;
      logic        idle;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic   rst_n;

   list_ptr_sync u_sync (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .rst_n_out (rst_n)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt        = st_r;
      st_nxt.rvalid = 1'b0;
      st_nxt.clr    = 1'b0;
      // Pointer stays put between frames
      if (ed_event_in.done) begin
         if (!ed_event_in.list_end) begin
            st_nxt.cur = ed_event_in.next_ptr;
         end else if (control_list_filled_in) begin
            st_nxt.cur = control_list_head_pointer_in;
            st_nxt.clr = 1'b1;
         end else begin
            st_nxt.cur = st_r.cur;
         end
      end else if (req_in.wr && req_in.addr == list_ptr_pkg::CTRL_CUR_OFS
                   && !control_list_enable_in) begin
         st_nxt.cur = req_in.wdata[31:list_ptr_pkg::PTR_LSB];
      end
      if (init_load_in) begin
         st_nxt.bulk = host_communication_area_bulk_head_in;
      end else if (req_in.wr
                   && req_in.addr == list_ptr_pkg::BULK_HEAD_OFS) begin
         st_nxt.bulk = req_in.wdata[31:list_ptr_pkg::PTR_LSB];
      end
      // Read returns an instantaneous snapshot
      if (req_in.rd) begin
         st_nxt.rvalid = 1'b1;
         if (req_in.addr == list_ptr_pkg::CTRL_CUR_OFS) begin
            st_nxt.rdata = list_ptr_pkg::ptr_to_word(st_r.cur);
         end else if (req_in.addr == list_ptr_pkg::BULK_HEAD_OFS) begin
            st_nxt.rdata = list_ptr_pkg::ptr_to_word(st_r.bulk);
         end else begin
            st_nxt.rdata = list_ptr_pkg::RESERVED_READ;
         end
      end
      st_nxt.cur_addr  = list_ptr_pkg::ptr_to_word(st_nxt.cur);
      if (bulk_start_in) begin
         st_nxt.bulk_addr = list_ptr_pkg::ptr_to_word(st_r.bulk);
      end
      st_nxt.idle = (st_nxt.cur == list_ptr_pkg::PTR_RESET);
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_r           <= '0;
         st_r.idle      <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata_out                = st_r.rdata;
   assign rvalid_out               = st_r.rvalid;
   assign clear_filled_out         = st_r.clr;
   assign control_current_addr_out = st_r.cur_addr;
   assign bulk_start_addr_out      = st_r.bulk_addr;
   assign control_list_idle_out    = st_r.idle;
endmodule : ohci_list_pointer_regs

// ### verif/list_ptr_assertions.sv
// Checker for the list-pointer bank, bound to its top module.
// Assumes stimulus begins after the internal reset release.
`timescale 1ns/100ps
module list_ptr_chk (
   input wire logic                    clk_in,
   input wire logic                    rst_n_in,
   input wire list_ptr_pkg::reg_req_t  req_in,
   input wire logic [27:0]             control_list_head_pointer_in,
   input wire logic                    control_list_filled_in,
   input wire logic                    control_list_enable_in,
   input wire list_ptr_pkg::ed_event_t ed_event_in,
   input wire logic                    init_load_in,
   input wire logic [27:0]             host_communication_area_bulk_head_in,
   input wire logic                    bulk_start_in,
   input wire logic [31:0]             rdata_out,
   input wire logic                    rvalid_out,
   input wire logic                    clear_filled_out,
   input wire logic [31:0]             control_current_addr_out,
   input wire logic [31:0]             bulk_start_addr_out,
   input wire logic                    control_list_idle_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_end(f);
      ed_event_in.done && ed_event_in.list_end && control_list_filled_in == f;
   endsequence
   sequence s_boot;
      init_load_in ##1 bulk_start_in;
   endsequence
   AST_RELOAD: assert property (s_end(1'b1) |=> clear_filled_out &&
      control_current_addr_out == {$past(control_list_head_pointer_in), 4'h0})
      else $error("reload at list end missing");
   AST_KEEP: assert property (s_end(1'b0) |=>
      !clear_filled_out && $stable(control_current_addr_out))
      else $error("list end without flag changed state");
   AST_ADV: assert property (ed_event_in.done && !ed_event_in.list_end |=>
      control_current_addr_out == {$past(ed_event_in.next_ptr), 4'h0})
      else $error("pointer did not advance");
   AST_LOCK: assert property (req_in.wr && req_in.addr == 8'h24 &&
      control_list_enable_in && !ed_event_in.done |=>
      $stable(control_current_addr_out)) else $error("locked write landed");
   AST_RVALID: assert property (req_in.rd |=> rvalid_out)
      else $error("read not answered");
   AST_RSV: assert property (rvalid_out |-> rdata_out[3:0] == 4'h0)
      else $error("reserved bits not zero");
   AST_IDLE: assert property (control_list_idle_out ==
      (control_current_addr_out == 32'h0000_0000)) else $error("idle wrong");
   AST_BOOT: assert property (s_boot |=>
      bulk_start_addr_out == {$past(host_communication_area_bulk_head_in, 2), 4'h0})
      else $error("bulk start address wrong");
endmodule : list_ptr_chk
bind ohci_list_pointer_regs list_ptr_chk chk (.*);

// ### verif/ohci_list_pointer_regs_bench.sv
// Self-checking bench for the list-pointer bank.
// Drives all ports directly; read answers are checked through a queue.
`timescale 1ns/100ps
module ohci_list_pointer_regs_bench;
   logic                    clk_in = 0, rst_n_in = 0, cle = 0, control_list_filled = 0;
   logic                    ld = 0, bs = 0, rvalid, clr, idle;
   logic [27:0]             head = 0, host_communication_area = 0;
   logic [31:0]             rdata, ccur, bstart, w, q[$];
   list_ptr_pkg::reg_req_t  req = '0;
   list_ptr_pkg::ed_event_t ev = '0;
   int                      errors = 0, samples_checked = 0, seed = 24;
   always #2 clk_in = ~clk_in;
   ohci_list_pointer_regs dut (.clk_in, .rst_n_in, .req_in(req),
      .control_list_head_pointer_in(head), .control_list_filled_in(control_list_filled),
      .control_list_enable_in(cle), .ed_event_in(ev), .init_load_in(ld),
      .host_communication_area_bulk_head_in(host_communication_area), .bulk_start_in(bs), .rdata_out(rdata),
      .rvalid_out(rvalid), .clear_filled_out(clr),
      .control_current_addr_out(ccur), .bulk_start_addr_out(bstart),
      .control_list_idle_out(idle));
   task automatic check(input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("mismatch %0t seen %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic op(input logic [1:0] k, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk_in) req <= '{k[1], k[0], a, d};
      @(posedge clk_in) req <= '0;
   endtask : op
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      op(2'b01, a, '0);
   endtask : rd
   task automatic step(input logic le, input logic [27:0] p);
      @(posedge clk_in) ev <= '{1'b1, le, p};
      @(posedge clk_in) ev <= '0;
   endtask : step
   task automatic close_out;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   always @(posedge clk_in)
      if (rvalid === 1'b1) check(rdata, q.pop_front());
   initial begin
      #4000;
      errors++;
      close_out;
   end
   initial begin
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      #1 check({31'h0, idle}, 32'h0000_0001);
      check(ccur, 32'h0000_0000);
      rd(8'h24, '0);
      rd(8'h28, '0);
      w = $random(seed) & 32'hffff_fff0;
      op(2'b10, 8'h28, w | 32'h0000_0005);
      rd(8'h28, w);
      op(2'b10, 8'h24, w);
      rd(8'h24, w);
      cle <= 1'b1;
      op(2'b10, 8'h24, 32'h0000_1230);
      rd(8'h24, w);
      rd(8'h30, '0);
      w = $random(seed) & 32'hffff_fff0;
      head <= 28'($random(seed));
      step(1'b0, w[31:4]);
      #1 check(ccur, w);
      rd(8'h24, w);
      step(1'b1, '0);
      rd(8'h24, w);
      control_list_filled <= 1'b1;
      step(1'b1, '0);
      control_list_filled <= 1'b0;
      #1 check({31'h0, clr}, 32'h0000_0001);
      check(ccur, {head, 4'h0});
      rd(8'h24, {head, 4'h0});
      host_communication_area <= 28'($random(seed));
      @(posedge clk_in) ld <= 1'b1;
      @(posedge clk_in) {ld, bs} <= 2'b01;
      @(posedge clk_in) bs <= 1'b0;
      #1 check(bstart, {host_communication_area, 4'h0});
      rd(8'h28, {host_communication_area, 4'h0});
      repeat (3) @(posedge clk_in);
      close_out;
   end
endmodule : ohci_list_pointer_regs_bench
